/* sdcc_top.sv */
// module: channel control, result access and interrupt vector of the sigma-delta converter
`default_nettype none
`timescale 1ns/1ps

module sdcc_top
  import sdcc_pkg::*;
#(
  parameter int N_CH    = 3,                  // channels, at most 8
  parameter int MAX_OSR = 1024                // largest oversampling ratio
)(
  input  wire logic             pclk,         // system clock, 100 MHz
  input  wire logic             presetn,      // async reset, active low
  input  wire logic             psel,         // apb select
  input  wire logic             penable,      // apb access phase
  input  wire logic             pwrite,       // apb direction
  input  wire logic [7:0]       paddr,        // apb byte address
  input  wire logic [31:0]      pwdata,       // apb write data
  output logic      [31:0]      prdata,       // apb read data
  output logic                  pready,       // apb ready
  output logic                  pslverr,      // apb error, unmapped address or write to the vector or a result register
  input  wire logic [N_CH-1:0]  mod_bit_in,   // modulator bit streams (async)
  output sdcc_anlg_t [N_CH-1:0] anlg_ctl,     // per-channel analog settings
  output logic                  irq           // level interrupt
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic [N_CH-1:0]       group, running, done, ovf, df, lsbacc, lsbtog, ie, ovie;
  logic [N_CH-1:0]       next_group, next_running, next_done, next_ovf, next_df;
  logic [N_CH-1:0]       next_lsbacc, next_lsbtog, next_ie, next_ovie;
  logic [N_CH-1:0][1:0]  osr, next_osr;
  logic [N_CH-1:0][7:0]  inctl, next_inctl, preload, next_preload;
  logic [N_CH-1:0][31:0] result, next_result;
  logic [N_CH-1:0][2:0]  nsamp, next_nsamp;
  logic [31:0]           next_prdata;
  logic                  next_pslverr;

  logic [N_CH-1:0]       sync1, sync2, go;
  sdcc_sample_t [N_CH-1:0] smp;
  logic [15:0]           vector;
  logic                  setup, access, wr, rd;

  assign setup  = psel & ~penable;
  assign access = psel & penable;
  assign wr     = access & pwrite;
  assign rd     = access & ~pwrite;
  assign pready = 1'b1;                                // zero wait states

  // ---------------------------------------------------------------------------
  // address decode helpers
  // ---------------------------------------------------------------------------
  function automatic logic is_ch(input logic [7:0] a, input logic [7:0] ofs, input int ch);
    is_ch = (a == (ofs | 8'(ch << CH_SHIFT)));
  endfunction

  function automatic logic [31:0] ch_word(input logic [15:0] lo);
    ch_word = {16'h0000, lo};
  endfunction

  // ---------------------------------------------------------------------------
  // modulator bit synchronisers, two flops each
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= mod_bit_in;
      sync2 <= sync1;
    end
  end

  // ---------------------------------------------------------------------------
  // filters, one per channel
  // ---------------------------------------------------------------------------
  for (genvar g = 0; g < N_CH; g++)
  begin : g_ch
    sdcc_decim #(
      .MAX_OSR  (MAX_OSR),
      .ACC_W    (24)
    ) u_decim (
      .pclk     (pclk),
      .presetn  (presetn),
      .run      (running[g]),
      .restart  (go[g]),
      .osr_code (osr[g]),
      .preload  (preload[g]),
      .mod_bit  (sync2[g]),
      .sample   (smp[g])
    );
    // gain and pair reach the analog side straight from the input control register; running comes from the run flag
    assign anlg_ctl[g] = '{running: running[g],
                           gain:    inctl[g][INC_GAIN +: 3],
                           pair:    inctl[g][INC_PAIR +: 3]};
  end

  // ---------------------------------------------------------------------------
  // interrupt vector and line
  // ---------------------------------------------------------------------------
  sdcc_prio #(
    .N_CH      (N_CH)
  ) u_prio (
    .done_pend (done & ie),
    .ovf_pend  (|(ovf & ovie)),
    .vector    (vector)
  );

  assign irq = (vector != VEC_NONE);

  // ---------------------------------------------------------------------------
  // start chain: a grouped channel passes its start to the next one
  // ---------------------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < N_CH; i++)
    begin
      go[i] = wr && is_ch(paddr, OFS_CH_CTRL, i) && pwdata[CTL_START];
      // a group bit written along with the start chains at once
      if (i > 0 && go[i-1] && ((wr && is_ch(paddr, OFS_CH_CTRL, i-1)) ? pwdata[CTL_GROUP] : group[i-1]))
        go[i] = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // register next values and read data
  // ---------------------------------------------------------------------------
  always_comb
  begin
    next_group   = group;
    next_running = running;
    next_done    = done;
    next_ovf     = ovf;
    next_df      = df;
    next_lsbacc  = lsbacc;
    next_lsbtog  = lsbtog;
    next_ie      = ie;
    next_ovie    = ovie;
    next_osr     = osr;
    next_inctl   = inctl;
    next_preload = preload;
    next_result  = result;
    next_nsamp   = nsamp;
    next_prdata  = prdata;
    next_pslverr = 1'b0;

    // read data captured in setup, answered in access
    if (setup)
    begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = 1'b1;
    end
    if (setup && (paddr == OFS_VECTOR))
    begin
      next_prdata  = {16'h0000, vector & 16'h001E};
      next_pslverr = pwrite;                           // read-only: writes refused
    end
    if (setup && (paddr == OFS_IRQ_STATUS || paddr == OFS_IRQ_MASK))
    begin
      next_prdata                  = 32'h0000_0000;
      next_prdata[IRQ_OVF +: N_CH] = (paddr == OFS_IRQ_STATUS) ? ovf : ovie;
      next_prdata[N_CH-1:0]        = (paddr == OFS_IRQ_STATUS) ? done : ie;
      next_pslverr = 1'b0;
    end

    for (int i = 0; i < N_CH; i++)
    begin
      if (setup && is_ch(paddr, OFS_CH_CTRL, i))
      begin
        next_prdata  = ch_word({6'h00, osr[i], lsbtog[i], lsbacc[i], ovf[i], df[i],
                                ie[i], done[i], running[i], group[i]});
        next_pslverr = 1'b0;
      end
      if (setup && is_ch(paddr, OFS_CH_INCTL, i))
      begin
        next_prdata  = ch_word({8'h00, inctl[i]});
        next_pslverr = 1'b0;
      end
      if (setup && is_ch(paddr, OFS_CH_RESULT, i))
      begin
        // offset binary by default; df flips the sign bit for two's complement
        next_prdata  = ch_word(lsbacc[i] ? result[i][15:0]
                              : (result[i][31:16] ^ {df[i], 15'h0000}));
        next_pslverr = pwrite;
      end
      if (setup && is_ch(paddr, OFS_CH_PRELOAD, i))
      begin
        next_prdata  = ch_word({8'h00, preload[i]});
        next_pslverr = 1'b0;
      end

      // software writes
      if (wr && is_ch(paddr, OFS_CH_CTRL, i))
      begin
        next_group[i]   = (i < N_CH - 1) ? pwdata[CTL_GROUP] : 1'b0;
        next_running[i] = pwdata[CTL_START];
        next_done[i]    = done[i] & pwdata[CTL_DONE];
        next_ie[i]      = pwdata[CTL_IE];
        next_df[i]      = pwdata[CTL_DF];
        next_ovf[i]     = ovf[i] & pwdata[CTL_OVF];
        next_lsbacc[i]  = pwdata[CTL_LSBACC];
        next_lsbtog[i]  = pwdata[CTL_LSBTOG];
        next_osr[i]     = pwdata[CTL_OSR +: 2];
      end
      if (wr && is_ch(paddr, OFS_CH_INCTL, i))
        next_inctl[i] = pwdata[7:0];
      if (wr && is_ch(paddr, OFS_CH_PRELOAD, i))
        next_preload[i] = pwdata[7:0];
      if (wr && paddr == OFS_IRQ_STATUS)
      begin
        if (pwdata[i])
          next_done[i] = 1'b0;
        if (pwdata[IRQ_OVF + i])
          next_ovf[i] = 1'b0;
      end
      if (wr && paddr == OFS_IRQ_MASK)
      begin
        next_ie[i]   = pwdata[i];
        next_ovie[i] = pwdata[IRQ_OVF + i];
      end

      // result read side effects, taken at the access edge
      if (rd && is_ch(paddr, OFS_CH_RESULT, i))
      begin
        next_done[i] = 1'b0;
        if (lsbtog[i])
          next_lsbacc[i] = ~lsbacc[i];
      end

      // conversion start restarts the first-flag delay
      if (go[i])
      begin
        next_running[i] = 1'b1;
        next_nsamp[i]   = 3'h0;
      end
      else if (running[i] && smp[i].valid)
      begin
        // keep new results; set wins over any clear in the same cycle
        next_result[i] = smp[i].data;
        if (nsamp[i] != DLY_FULL)
          next_nsamp[i] = nsamp[i] + 3'h1;
        if ((nsamp[i] + 3'h1) >= sdcc_dly_target(inctl[i][INC_DLY +: 2]))
        begin
          if (done[i])
            next_ovf[i] = 1'b1;                        // unread result overwritten
          next_done[i] = 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      group   <= '0;
      running <= '0;
      done    <= '0;
      ovf     <= '0;
      df      <= '0;
      lsbacc  <= '0;
      lsbtog  <= '0;
      ie      <= '0;
      ovie    <= '0;
      osr     <= '0;
      inctl   <= {N_CH{INCTL_RST}};
      preload <= {N_CH{PRELOAD_RST}};
      result  <= '0;
      nsamp   <= '0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else
    begin
      group   <= next_group;
      running <= next_running;
      done    <= next_done;
      ovf     <= next_ovf;
      df      <= next_df;
      lsbacc  <= next_lsbacc;
      lsbtog  <= next_lsbtog;
      ie      <= next_ie;
      ovie    <= next_ovie;
      osr     <= next_osr;
      inctl   <= next_inctl;
      preload <= next_preload;
      result  <= next_result;
      nsamp   <= next_nsamp;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

endmodule

`default_nettype wire

/* sdcc_pkg.sv */
// package: register map, field layout and carriers of the converter channel control
`default_nettype none

package sdcc_pkg;

  // ---------------------------------------------------------------------------
  // byte addresses
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_CH_CTRL    = 8'h00;
  localparam logic [7:0] OFS_CH_INCTL   = 8'h04;
  localparam logic [7:0] OFS_CH_RESULT  = 8'h08;
  localparam logic [7:0] OFS_CH_PRELOAD = 8'h0C;
  localparam logic [7:0] OFS_VECTOR     = 8'h80;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h84;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h88;
  localparam int         CH_SHIFT       = 4;    // channel block stride is 16 bytes

  // ---------------------------------------------------------------------------
  // channel control field positions
  // ---------------------------------------------------------------------------
  localparam int CTL_GROUP  = 0;
  localparam int CTL_START  = 1;
  localparam int CTL_DONE   = 2;
  localparam int CTL_IE     = 3;
  localparam int CTL_DF     = 4;
  localparam int CTL_OVF    = 5;
  localparam int CTL_LSBACC = 6;
  localparam int CTL_LSBTOG = 7;
  localparam int CTL_OSR    = 8;  // two bits
  localparam int INC_PAIR   = 0;  // three bits
  localparam int INC_GAIN   = 3;  // three bits
  localparam int INC_DLY    = 6;  // two bits
  localparam int IRQ_OVF    = 8;  // overflow bits start here in status and mask

  // ---------------------------------------------------------------------------
  // reset values and vector codes
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  INCTL_RST   = 8'h00;
  localparam logic [7:0]  PRELOAD_RST = 8'h00;
  localparam logic [15:0] VEC_NONE    = 16'h0000;
  localparam logic [15:0] VEC_OVF     = 16'h0002;
  localparam logic [15:0] VEC_CH0     = 16'h0004;
  localparam logic [15:0] VEC_STEP    = 16'h0002;
  localparam logic [2:0]  DLY_FULL    = 3'h4;   // delay code 00 waits for the fourth sample

  // ---------------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic       running;  // modulator powered and converting
    logic [2:0] gain;     // amplifier gain code
    logic [2:0] pair;     // differential input pair code
  } sdcc_anlg_t;

  typedef struct packed {
    logic        valid;   // one-cycle pulse per decimated sample
    logic [31:0] data;    // filter output
  } sdcc_sample_t;

  // sample number that raises the first flag: code 00 -> 4 ... 11 -> 1
  function automatic logic [2:0] sdcc_dly_target(input logic [1:0] code);
    sdcc_dly_target = DLY_FULL - {1'b0, code};
  endfunction

endpackage

`default_nettype wire

/* sdcc_decim.sv */
// module: per-channel decimation filter fed by the modulator bit stream
`default_nettype none
`timescale 1ns/1ps

module sdcc_decim
  import sdcc_pkg::*;
#(
  parameter int MAX_OSR = 1024,               // largest oversampling ratio
  parameter int ACC_W   = 24                  // accumulator width
)(
  input  wire logic         pclk,             // system clock
  input  wire logic         presetn,          // async reset, active low
  input  wire logic         run,              // channel converting
  input  wire logic         restart,          // pulse: reseed from preload
  input  wire logic [1:0]   osr_code,         // ratio = MAX_OSR >> code
  input  wire logic [7:0]   preload,          // filter seed
  input  wire logic         mod_bit,          // synchronised modulator bit
  output sdcc_sample_t      sample            // decimated result
);

  localparam int CNT_W = $clog2(MAX_OSR) + 1;
  localparam logic [CNT_W-1:0] OSR_MAX = CNT_W'(MAX_OSR);

  logic [CNT_W-1:0] cnt, next_cnt;
  logic [ACC_W-1:0] acc, next_acc;
  sdcc_sample_t     next_sample;
  logic [CNT_W-1:0] last;

  // ---------------------------------------------------------------------------
  // count ones over one ratio window, then emit and reseed
  // ---------------------------------------------------------------------------
  always_comb
  begin
    last        = (OSR_MAX >> osr_code) - CNT_W'(1);
    next_cnt    = cnt;
    next_acc    = acc;
    next_sample = '{valid: 1'b0, data: sample.data};
    if (restart || !run)
    begin
      next_cnt = '0;
      next_acc = ACC_W'(preload);
    end
    else
    begin
      next_acc = acc + ACC_W'(mod_bit);
      next_cnt = cnt + CNT_W'(1);
      if (cnt == last)
      begin
        next_sample.valid = 1'b1;
        next_sample.data  = {next_acc, 8'h00};        // full scale lands in upper word for ratios of 256 and up
        next_cnt          = '0;
        next_acc          = ACC_W'(preload);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt    <= '0;
      acc    <= '0;
      sample <= '0;
    end
    else
    begin
      cnt    <= next_cnt;
      acc    <= next_acc;
      sample <= next_sample;
    end
  end

endmodule

`default_nettype wire

/* sdcc_prio.sv */
// module: priority encoder building the interrupt vector code
`default_nettype none
`timescale 1ns/1ps

module sdcc_prio
  import sdcc_pkg::*;
#(
  parameter int N_CH = 3                      // channel count
)(
  input  wire logic [N_CH-1:0] done_pend,     // enabled done flags
  input  wire logic            ovf_pend,      // any enabled overflow
  output logic      [15:0]     vector         // vector code
);

  // ---------------------------------------------------------------------------
  // overflow first, then channel 0 upward; low channels win
  // ---------------------------------------------------------------------------
  always_comb
  begin
    vector = VEC_NONE;
    for (int i = N_CH - 1; i >= 0; i--)
    begin
      if (done_pend[i])
        vector = VEC_CH0 + VEC_STEP * 16'(i);
    end
    if (ovf_pend)
      vector = VEC_OVF;
  end

endmodule

`default_nettype wire

/* sdcc_properties.sv */
// checker: port-level assertions of the converter channel control
`default_nettype none
`timescale 1ns/1ps

module sdcc_properties
  import sdcc_pkg::*;
#(
  parameter int N_CH    = 3,    // channels
  parameter int MAX_OSR = 1024  // largest ratio
)(
  input wire logic             pclk,       // clock
  input wire logic             presetn,    // reset, active low
  input wire logic             psel,       // apb select
  input wire logic             penable,    // apb access
  input wire logic             pwrite,     // apb direction
  input wire logic [7:0]       paddr,      // apb address
  input wire logic [31:0]      pwdata,     // apb write data
  input wire logic [31:0]      prdata,     // apb read data
  input wire logic             pready,     // apb ready
  input wire logic             pslverr,    // apb error
  input wire logic [N_CH-1:0]  mod_bit_in, // modulator bits
  input wire sdcc_anlg_t [N_CH-1:0] anlg_ctl, // analog settings
  input wire logic             irq         // interrupt
);
  // ---------------------------------------------------------------------------
  // bus phases
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // write access phase at one address
  sequence s_wr(logic [7:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  // read setup phase, where read data is chosen
  sequence s_rd_setup(logic [7:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence

  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  property p_ready;
    psel && penable |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("access without ready");
  property p_start;
    s_wr(OFS_CH_CTRL) ##0 pwdata[CTL_START] |=> anlg_ctl[0].running;
  endproperty
  a_start: assert property (p_start) else $error("start did not run");
  property p_no_start;
    s_wr(OFS_CH_CTRL) ##0 !pwdata[CTL_START] |=> !anlg_ctl[0].running;
  endproperty
  a_no_start: assert property (p_no_start) else $error("zero started");
  // grouped start of channel 1 must carry channel 2 along
  property p_group;
    s_wr(8'h10) ##0 pwdata[CTL_START] && pwdata[CTL_GROUP] |=> anlg_ctl[2].running;
  endproperty
  a_group: assert property (p_group) else $error("group not chained");
  property p_inctl;
    s_wr(OFS_CH_INCTL + 8'h10) |=> anlg_ctl[1].gain == $past(pwdata[5:3])
      && anlg_ctl[1].pair == $past(pwdata[2:0]);
  endproperty
  a_inctl: assert property (p_inctl) else $error("gain or pair wrong");
  property p_vec_bits;
    s_rd_setup(OFS_VECTOR) |=> prdata[31:5] == '0 && !prdata[0];
  endproperty
  a_vec_bits: assert property (p_vec_bits) else $error("vector bits set");
  property p_vec_range;
    s_rd_setup(OFS_VECTOR) |=> prdata[15:0] <= VEC_CH0 + 16'(2 * (N_CH - 1));
  endproperty
  a_vec_range: assert property (p_vec_range) else $error("vector code");
  // irq is sampled at the edge that loads the read data
  property p_vec_irq;
    s_rd_setup(OFS_VECTOR) |=> (prdata != '0) == $past(irq);
  endproperty
  a_vec_irq: assert property (p_vec_irq) else $error("irq vs vector");
  property p_vec_ro;
    s_wr(OFS_VECTOR) |-> pslverr;
  endproperty
  a_vec_ro: assert property (p_vec_ro) else $error("vector write taken");
  property p_unmapped;
    psel && penable && paddr == 8'h40 |-> pslverr && prdata == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("gap answered");
endmodule

bind sdcc_top sdcc_properties #(.N_CH(N_CH), .MAX_OSR(MAX_OSR)) sdcc_properties_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .mod_bit_in(mod_bit_in),
  .anlg_ctl(anlg_ctl), .irq(irq)
);

`default_nettype wire

/* sdcc_mod_model.sv */
// partner: modulator bit streams of the analog channels
`default_nettype none
`timescale 1ns/1ps

module sdcc_mod_model
  import sdcc_pkg::*;
#(
  parameter int N_CH = 3  // channels
)(
  input  wire logic                  pclk,     // clock
  input  wire sdcc_anlg_t [N_CH-1:0] anlg_ctl, // analog settings
  output logic [N_CH-1:0]            mod_bit   // bit streams
);
  // full scale while converting; an unpowered modulator flips each
  // cycle so that no stale level can pass for data
  initial mod_bit = '0;
  always @(posedge pclk)
  begin
    for (int c = 0; c < N_CH; c++)
    begin
      mod_bit[c] <= anlg_ctl[c].running ? 1'b1 : ~mod_bit[c];
    end
  end
endmodule

`default_nettype wire

/* sdcc_top_tb.sv */
// testbench: registers, conversion and interrupt of the channel control
`default_nettype none
`timescale 1ns/1ps

module sdcc_top_tb
  import sdcc_pkg::*;
;
  logic             pclk;
  logic             presetn;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [7:0]       paddr;
  logic [31:0]      pwdata;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic [2:0]       mod_bit;
  sdcc_anlg_t [2:0] anlg_ctl;
  logic             irq;
  logic [31:0]      rd;
  logic             er;
  int               fails;
  int               compares;
  int               cycles;

  sdcc_top #(.N_CH(3), .MAX_OSR(1024)) sdcc_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mod_bit_in(mod_bit),
    .anlg_ctl(anlg_ctl), .irq(irq)
  );
  sdcc_mod_model #(.N_CH(3)) sdcc_mod_model_i (
    .pclk(pclk), .anlg_ctl(anlg_ctl), .mod_bit(mod_bit)
  );

  // ---------------------------------------------------------------------------
  // clock, timeout and helpers
  // ---------------------------------------------------------------------------
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  // a hung wait ends here as a failure
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    for (int c = 0; c < 3; c++)
      rdchk(OFS_CH_INCTL + 8'(16 * c), 32'h0000_0000);
    rdchk(OFS_VECTOR, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    check({11'h0, anlg_ctl}, 32'h0000_0000);
  endtask

  // every gain and pair code, with all delay codes on the way
  task automatic t_inctl();
    logic [7:0] v;
    for (int i = 0; i < 8; i++)
    begin
      v = {2'(i), 3'(i), 3'(7 - i)};
      apb(1'b1, OFS_CH_INCTL + 8'h10, {24'h0, v});
      rdchk(OFS_CH_INCTL + 8'h10, {24'h0, v});
      check({29'h0, anlg_ctl[1].gain}, {29'h0, v[5:3]});
      check({29'h0, anlg_ctl[1].pair}, {29'h0, v[2:0]});
    end
  endtask

  task automatic t_access();
    apb(1'b1, OFS_CH_PRELOAD + 8'h20, 32'h0000_01A5);
    rdchk(OFS_CH_PRELOAD + 8'h20, 32'h0000_00A5);
    apb(1'b1, OFS_VECTOR, 32'h0000_00FF);
    check({31'h0, er}, 32'h0000_0001);
    rdchk(OFS_VECTOR, 32'h0000_0000);
    rdchk(8'h40, 32'h0000_0000);
    check({31'h0, er}, 32'h0000_0001);
  endtask

  // group on channel 1 carries channel 2; the last channel has no group
  task automatic t_group();
    apb(1'b1, 8'h10, 32'h0000_0003);
    @(negedge pclk);
    check({31'h0, anlg_ctl[2].running}, 32'h0000_0001);
    apb(1'b1, 8'h20, 32'h0000_0001);
    rdchk(8'h20, 32'h0000_0000);
    apb(1'b1, 8'h10, 32'h0000_0000);
    apb(1'b1, OFS_CH_CTRL, 32'h0000_0000);
    @(negedge pclk);
    check({29'h0, anlg_ctl[2].running, anlg_ctl[1].running,
      anlg_ctl[0].running}, 32'h0000_0000);
  endtask

  // ratio 128, preload F0h, full-scale ones: result word 0001_7000h
  task automatic t_conv();
    int n;
    apb(1'b1, OFS_CH_PRELOAD, 32'h0000_00F0);
    apb(1'b1, OFS_CH_INCTL, 32'h0000_0080);
    apb(1'b1, OFS_CH_CTRL, 32'h0000_030A);
    repeat (140) @(posedge pclk);
    check({31'h0, irq}, 32'h0000_0000);
    n = 0;
    while (irq !== 1'b1 && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    check({31'h0, irq}, 32'h0000_0001);
    rdchk(OFS_VECTOR, 32'h0000_0004);
    apb(1'b0, OFS_CH_CTRL, 32'h0000_0000);
    check({31'h0, rd[CTL_DONE]}, 32'h0000_0001);
    apb(1'b1, OFS_CH_CTRL, 32'h0000_039E);
    rdchk(OFS_CH_RESULT, 32'h0000_8001);
    rdchk(OFS_CH_RESULT, 32'h0000_7000);
    check({31'h0, irq}, 32'h0000_0000);
    // unread samples pile up into an overflow
    apb(1'b1, OFS_IRQ_MASK, 32'h0000_0101);
    repeat (400) @(posedge pclk);
    rdchk(OFS_VECTOR, 32'h0000_0002);
    for (int c = 0; c < 3; c++)
    begin
      apb(1'b0, OFS_CH_CTRL + 8'(16 * c), 32'h0000_0000);
      check({31'h0, rd[CTL_OVF]}, {31'h0, c == 0});
    end
    apb(1'b1, OFS_CH_CTRL, 32'h0000_0300);
    @(negedge pclk);
    check({31'h0, anlg_ctl[0].running}, 32'h0000_0000);
    rdchk(OFS_VECTOR, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    presetn = 1'b0;
    fails = 0;
    compares = 0;
    cycles = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_inctl();
    t_access();
    t_group();
    t_conv();
    wrap_up();
  end
endmodule

`default_nettype wire
